/* File: design/power_mode_reset_sequencer.v */
// What this block does
// - Deep-off state halts everything; only external wake events or loss of supply leave it
// - Every exit from deep-off goes through a full reboot
// - Retention flags keep marked registers through deep-off and reboot
// - Wake on module reset, sensor rising event, or VBUS appearing
// - NFC field detection also wakes from deep-off
// - On state offers run or idle per software choice
// - Only one idle sub-mode, constant-latency or low-power, at a time
// - Constant-latency mode wakes the CPU after a fixed latency
// - Low-power sub-mode selected after reset; CPU wakes on the first run cycle, no latency count
// - After any reset, idle sub-mode returns to its stored default; the retention mask clears only on power-on reset
// - Low level on active-low reset pin forces hardware reset
// - Supply rising above power-on threshold causes power-on reset
// - Supply falling below brownout threshold causes reset
// - Waking from deep-off generates a reset
// - Software reset request produces a soft reset
// - Watchdog expiry produces a reset
`timescale 1ns/1ps
`include "pwr_seq_defines.vh"

module power_mode_reset_sequencer #(
   parameter HOLD_CYC = `RST_HOLD_CYC,
   parameter RET_W = 8
) (
   input wire ref_clk,
   input wire rst,
   input wire reset_pin_n,
   input wire por_ok,
   input wire brownout,
   input wire sensor_evt,
   input wire nfc_field,
   input wire vbus_present,
   input wire soft_reset_req,
   input wire wdt_expired,
   input wire off_req,
   input wire idle_req,
   input wire wake_irq,
   input wire cfg_write,
   input wire cfg_const_lat,
   input wire [RET_W-1:0] ret_mask_in,
   input wire [RET_W-1:0] ret_data_in,
   input wire ret_write,
   output wire sys_reset,
   output reg [2:0] power_state,
   output reg cpu_clk_en,
   output reg idle_const_lat,
   output reg [2:0] reset_cause,
   output reg [RET_W-1:0] ret_data,
   output reg wake_done
);
   localparam CW = 16;

   // Pins pass the two-stage synchroniser
   wire [`WK_N-1:0] wk_raw;
   wire [`WK_N-1:0] wk_lvl;
   wire [`WK_N-1:0] wk_rise;
   wire [2:0] ext_raw;
   reg [2:0] ext_s1_reg;
   reg [2:0] ext_s2_reg;

   assign wk_raw[`WK_PIN] = ~reset_pin_n;
   assign wk_raw[`WK_SENSOR] = sensor_evt;
   assign wk_raw[`WK_NFC] = nfc_field;
   assign wk_raw[`WK_VBUS] = vbus_present;
   assign ext_raw = {wdt_expired, brownout, por_ok};

   wake_sync #(
      .W(`WK_N)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .async_in(wk_raw),
      .level(wk_lvl),
      .rise(wk_rise)
   );

   always @(posedge ref_clk) begin
      if (rst) begin
         ext_s1_reg <= 3'h0;
         ext_s2_reg <= 3'h0;
      end else begin
         ext_s1_reg <= ext_raw;
         ext_s2_reg <= ext_s1_reg;
      end
   end

   wire por_ok_s = ext_s2_reg[0];
   wire bod_s = ext_s2_reg[1];
   wire wdt_s = ext_s2_reg[2];
   wire pin_low = wk_lvl[`WK_PIN];

   // Any external wake source; sensor flags on rising level only
   wire wake_any = wk_lvl[`WK_PIN] | wk_rise[`WK_SENSOR]
                   | wk_rise[`WK_NFC]
                   | wk_rise[`WK_VBUS];

   function [CW-1:0] clip_cnt;
      input integer v;
      begin
         clip_cnt = (v < 1) ? 16'h0001 : v[CW-1:0];
      end
   endfunction

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [CW-1:0] cnt_reg;
   reg [CW-1:0] cnt_next;
   reg [2:0] cause_next;
   reg [1:0] lat_reg;
   reg idle_mode_reg;
   reg [RET_W-1:0] ret_mask_reg;

   wire hold_reset = (state_reg == `ST_POR) || (state_reg == `ST_RESET)
                     || (state_reg == `ST_WAKE);
   assign sys_reset = hold_reset;

   // Reset source priority, power-related first
   always @* begin
      cause_next = `CAUSE_NONE;
      if (!por_ok_s)
         cause_next = `CAUSE_POR;
      else if (bod_s)
         cause_next = `CAUSE_BOD;
      else if (pin_low)
         cause_next = `CAUSE_PIN;
      else if (wdt_s)
         cause_next = `CAUSE_WDT;
      else if (soft_reset_req)
         cause_next = `CAUSE_SOFT;
   end

   always @* begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         `ST_POR: begin
            // Held until supply is good, then one full hold period
            if (!por_ok_s) begin
               cnt_next = clip_cnt(HOLD_CYC);
            end else if (cnt_reg > 16'h0001) begin
               cnt_next = cnt_reg - 16'h0001;
            end else begin
               state_next = `ST_RUN;
            end
         end
         `ST_RESET, `ST_WAKE: begin
            // A pin still low after waking keeps the wake reset going
            if (cause_next != `CAUSE_NONE) begin
               cnt_next = clip_cnt(HOLD_CYC);
               if (cause_next == `CAUSE_POR)
                  state_next = `ST_POR;
               else if (state_reg == `ST_WAKE)
                  state_next = `ST_WAKE;
               else
                  state_next = `ST_RESET;
            end else if (cnt_reg > 16'h0001) begin
               cnt_next = cnt_reg - 16'h0001;
            end else begin
               state_next = `ST_RUN;
            end
         end
         `ST_RUN, `ST_IDLE: begin
            if (cause_next != `CAUSE_NONE) begin
               cnt_next = clip_cnt(HOLD_CYC);
               state_next = (cause_next == `CAUSE_POR) ? `ST_POR : `ST_RESET;
            end else if (off_req) begin
               state_next = `ST_OFF;
            end else if (state_reg == `ST_RUN) begin
               if (idle_req)
                  state_next = `ST_IDLE;
            end else if (wake_irq || !idle_req) begin
               state_next = `ST_RUN;
            end
         end
         `ST_OFF: begin
            // Only external events leave, and always through a reboot
            if (!por_ok_s) begin
               cnt_next = clip_cnt(HOLD_CYC);
               state_next = `ST_POR;
            end else if (wake_any) begin
               cnt_next = clip_cnt(HOLD_CYC);
               state_next = `ST_WAKE;
            end
         end
         default: begin
            state_next = `ST_POR;
            cnt_next = clip_cnt(HOLD_CYC);
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         state_reg <= `ST_POR;
         cnt_reg <= 16'h0001;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // Cause latch: WAKE on a deep-off wake, else updated while a source is active outside off and wake; held through run
   always @(posedge ref_clk) begin
      if (rst) begin
         reset_cause <= `CAUSE_POR;
      end else if (state_reg == `ST_OFF && state_next == `ST_WAKE) begin
         reset_cause <= `CAUSE_WAKE;
      end else if (cause_next != `CAUSE_NONE &&
                   state_reg != `ST_OFF && state_reg != `ST_WAKE) begin
         reset_cause <= cause_next;
      end
   end

   // Idle sub-mode: one bit, so exactly one mode is ever active
   always @(posedge ref_clk) begin
      if (rst || hold_reset) begin
         idle_mode_reg <= `IDLE_RESET;
      end else if (cfg_write) begin
         idle_mode_reg <= cfg_const_lat;
      end
   end

   // Wake latency from idle: fixed in constant-latency mode
   always @(posedge ref_clk) begin
      if (rst || hold_reset) begin
         lat_reg <= 2'h0;
         cpu_clk_en <= 1'b0;
         wake_done <= 1'b0;
      end else begin
         wake_done <= 1'b0;
         if (state_reg == `ST_IDLE) begin
            cpu_clk_en <= (idle_mode_reg == `IDLE_CONST) ? 1'b0 : 1'b0;
            lat_reg <= (idle_mode_reg == `IDLE_CONST) ?
                       `CONST_WAKE_CYC : 2'h0;
         end else if (state_reg == `ST_RUN) begin
            if (lat_reg != 2'h0) begin
               lat_reg <= lat_reg - 2'h1;
               if (lat_reg == 2'h1) begin
                  cpu_clk_en <= 1'b1;
                  wake_done <= 1'b1;
               end
            end else if (!cpu_clk_en) begin
               // Low-power path: wake as soon as possible
               cpu_clk_en <= 1'b1;
               wake_done <= 1'b1;
            end
         end else begin
            cpu_clk_en <= 1'b0;
         end
      end
   end

   // Retained registers survive deep-off and reboot; others clear
   always @(posedge ref_clk) begin
      if (rst) begin
         ret_mask_reg <= {RET_W{1'b0}};
         ret_data <= {RET_W{1'b0}};
      end else if (state_reg == `ST_POR) begin
         ret_mask_reg <= {RET_W{1'b0}};
         ret_data <= {RET_W{1'b0}};
      end else if (hold_reset) begin
         ret_data <= ret_data & ret_mask_reg;
      end else begin
         if (cfg_write)
            ret_mask_reg <= ret_mask_in;
         if (ret_write)
            ret_data <= ret_data_in;
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         power_state <= `ST_POR;
         idle_const_lat <= `IDLE_RESET;
      end else begin
         power_state <= state_reg;
         idle_const_lat <= idle_mode_reg;
      end
   end
endmodule

/* File: design/pwr_seq_defines.vh */
`ifndef PWR_SEQ_DEFINES_VH
`define PWR_SEQ_DEFINES_VH

// Power states
`define ST_POR      3'h0
`define ST_RESET    3'h1
`define ST_RUN      3'h2
`define ST_IDLE     3'h3
`define ST_OFF      3'h4
`define ST_WAKE     3'h5

// Reset cause codes
`define CAUSE_NONE  3'h0
`define CAUSE_POR   3'h1
`define CAUSE_PIN   3'h2
`define CAUSE_BOD   3'h3
`define CAUSE_WAKE  3'h4
`define CAUSE_SOFT  3'h5
`define CAUSE_WDT   3'h6

// Idle sub-mode select
`define IDLE_LOWPWR 1'b0
`define IDLE_CONST  1'b1
`define IDLE_RESET  `IDLE_LOWPWR

// Wake source bit positions
`define WK_PIN      0
`define WK_SENSOR   1
`define WK_NFC      2
`define WK_VBUS     3
`define WK_N        4

// Timing
`define RST_HOLD_NS     400
`define CLK_PERIOD_NS   40
`define RST_HOLD_CYC    ((`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONST_WAKE_CYC  2'h2

`endif

/* File: design/wake_sync.v */
`timescale 1ns/1ps
`include "pwr_seq_defines.vh"

// Two-stage synchroniser plus rising-edge detect per bit
module wake_sync #(
   parameter W = 4
) (
   input wire ref_clk,
   input wire rst,
   input wire [W-1:0] async_in,
   output wire [W-1:0] level,
   output wire [W-1:0] rise
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   reg [W-1:0] s3_reg;

   always @(posedge ref_clk) begin
      if (rst) begin
         s1_reg <= {W{1'b0}};
         s2_reg <= {W{1'b0}};
         s3_reg <= {W{1'b0}};
      end else begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   assign level = s2_reg;
   assign rise = s2_reg & ~s3_reg;
endmodule

/* File: tb/pmrs_props.sv */
`timescale 1ns/1ps
`include "pwr_seq_defines.vh"
module pmrs_props #(
   parameter HOLD_CYC = 1
) (
   input wire ref_clk,
   input wire rst,
   input wire reset_pin_n,
   input wire por_ok,
   input wire brownout,
   input wire sensor_evt,
   input wire nfc_field,
   input wire vbus_present,
   input wire soft_reset_req,
   input wire wdt_expired,
   input wire cfg_write,
   input wire sys_reset,
   input wire [2:0] power_state,
   input wire cpu_clk_en,
   input wire idle_const_lat,
   input wire [2:0] reset_cause,
   input wire wake_done
);
   reg [7:0] hi_cnt;
   reg [3:0] quiet_cnt;
   reg [4:0] prev_in;
   wire [4:0] cur_in = {sensor_evt, nfc_field, vbus_present, reset_pin_n, por_ok};
   // Length of the current reset pulse; input quiet time
   always @(posedge ref_clk) begin
      prev_in <= cur_in;
      if (rst || !sys_reset) hi_cnt <= 8'h0;
      else if (hi_cnt != 8'hff) hi_cnt <= hi_cnt + 8'h1;
      if (rst || cur_in != prev_in || !reset_pin_n || !por_ok || brownout)
         quiet_cnt <= 4'h0;
      else if (quiet_cnt != 4'hf) quiet_cnt <= quiet_cnt + 4'h1;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_RST_DEFAULTS: assert property ($fell(rst) |-> sys_reset &&
      reset_cause == `CAUSE_POR && idle_const_lat == `IDLE_RESET)
      else $error("reset defaults wrong");
   AST_PIN_RESET: assert property (!reset_pin_n [*5] |-> sys_reset)
      else $error("pin low gave no reset");
   AST_BOD_RESET: assert property (brownout [*5] |-> sys_reset)
      else $error("brownout gave no reset");
   AST_WDT_RESET: assert property ((wdt_expired && power_state != `ST_OFF)
      [*5] |-> sys_reset) else $error("watchdog gave no reset");
   AST_SOFT_RESET: assert property (soft_reset_req && power_state == `ST_RUN
      |=> sys_reset ##[0:2] reset_cause == `CAUSE_SOFT)
      else $error("soft reset missing");
   AST_RESET_HOLD: assert property ($fell(sys_reset) |-> hi_cnt >= HOLD_CYC)
      else $error("reset pulse too short");
   AST_OFF_HOLDS: assert property (power_state == `ST_OFF &&
      quiet_cnt >= 4'h6 |=> power_state == `ST_OFF)
      else $error("left deep-off without wake");
   AST_OFF_EXIT: assert property ($past(power_state) == `ST_OFF &&
      power_state != `ST_OFF |-> power_state != `ST_RUN &&
      power_state != `ST_IDLE) else $error("deep-off exit without reboot");
   AST_WAKE_CAUSE: assert property (power_state == `ST_WAKE |->
      ##[0:1] reset_cause == `CAUSE_WAKE) else $error("wake cause wrong");
   AST_CPU_HALT: assert property (sys_reset |=> !cpu_clk_en)
      else $error("cpu runs during reset");
   AST_IDLE_SELECT: assert property ($changed(idle_const_lat) |->
      $past(cfg_write, 2) || $past(sys_reset, 2))
      else $error("idle mode changed");
   AST_WAKE_DONE: assert property (wake_done |-> cpu_clk_en ##1 !wake_done)
      else $error("wake done pulse wrong");
   cover property (power_state == `ST_WAKE);
   cover property (power_state == `ST_IDLE);
   cover property (wake_done);
   cover property (reset_cause == `CAUSE_WDT);
endmodule

bind power_mode_reset_sequencer pmrs_props #(.HOLD_CYC(HOLD_CYC)) u_pmrs_props (
   .ref_clk(ref_clk),
   .rst(rst),
   .reset_pin_n(reset_pin_n),
   .por_ok(por_ok),
   .brownout(brownout),
   .sensor_evt(sensor_evt),
   .nfc_field(nfc_field),
   .vbus_present(vbus_present),
   .soft_reset_req(soft_reset_req),
   .wdt_expired(wdt_expired),
   .cfg_write(cfg_write),
   .sys_reset(sys_reset),
   .power_state(power_state),
   .cpu_clk_en(cpu_clk_en),
   .idle_const_lat(idle_const_lat),
   .reset_cause(reset_cause),
   .wake_done(wake_done)
);

/* File: tb/wake_partner.sv */
`timescale 1ns/1ps
`include "pwr_seq_defines.vh"
module wake_partner (
   input wire ref_clk,
   input wire [3:0] fire,
   output wire reset_pin_n,
   output wire sensor_evt,
   output wire nfc_field,
   output wire vbus_present
);
   reg [3:0] act = 4'h0;
   reg [2:0] cnt = 3'h0;
   // Each event held some cycles, then released
   always @(posedge ref_clk) begin
      if (fire != 4'h0) begin
         act <= #1 fire;
         cnt <= #1 3'h6;
      end else if (cnt != 3'h0) begin
         cnt <= #1 cnt - 3'h1;
      end else begin
         act <= #1 4'h0;
      end
   end
   // Released pin is driven high as the inverse of its act bit
   assign reset_pin_n = ~act[`WK_PIN];
   assign sensor_evt = act[`WK_SENSOR];
   assign nfc_field = act[`WK_NFC];
   assign vbus_present = act[`WK_VBUS];
endmodule

/* File: tb/power_mode_reset_sequencer_bench.sv */
`timescale 1ns/1ps
`include "pwr_seq_defines.vh"
module power_mode_reset_sequencer_bench;
   reg ref_clk = 1'h0;
   reg rst = 1'h1;
   reg por_ok = 1'h1, brownout = 1'h0, soft_reset_req = 1'h0;
   reg wdt_expired = 1'h0, off_req = 1'h0, idle_req = 1'h0, wake_irq = 1'h0;
   reg cfg_write = 1'h0, cfg_const_lat = 1'h0, ret_write = 1'h0;
   reg [7:0] ret_mask_in = 8'h0, ret_data_in = 8'h0;
   reg [3:0] fire = 4'h0;
   wire reset_pin_n, sensor_evt, nfc_field, vbus_present, sys_reset;
   wire cpu_clk_en, idle_const_lat, wake_done;
   wire [2:0] power_state, reset_cause;
   wire [7:0] ret_data;
   integer err_count = 0, compares = 0, i, n;
   power_mode_reset_sequencer #(.HOLD_CYC(3)) u_power_mode_reset_sequencer (
      .ref_clk(ref_clk), .rst(rst), .reset_pin_n(reset_pin_n),
      .por_ok(por_ok), .brownout(brownout), .sensor_evt(sensor_evt),
      .nfc_field(nfc_field), .vbus_present(vbus_present),
      .soft_reset_req(soft_reset_req), .wdt_expired(wdt_expired),
      .off_req(off_req), .idle_req(idle_req), .wake_irq(wake_irq),
      .cfg_write(cfg_write), .cfg_const_lat(cfg_const_lat),
      .ret_mask_in(ret_mask_in), .ret_data_in(ret_data_in),
      .ret_write(ret_write), .sys_reset(sys_reset),
      .power_state(power_state), .cpu_clk_en(cpu_clk_en),
      .idle_const_lat(idle_const_lat), .reset_cause(reset_cause),
      .ret_data(ret_data), .wake_done(wake_done));
   wake_partner u_wake_partner (.ref_clk(ref_clk), .fire(fire),
      .reset_pin_n(reset_pin_n), .sensor_evt(sensor_evt),
      .nfc_field(nfc_field), .vbus_present(vbus_present));
   initial forever #20 ref_clk = ~ref_clk;
   task tick(input integer k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task chk(input string nm, input [7:0] exp, input [7:0] got);
      compares = compares + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task wait_run;
      tick(6);
      n = 0;
      while (!(power_state === `ST_RUN && cpu_clk_en === 1'h1) && n < 200) begin
         tick(1);
         n = n + 1;
      end
      chk("run", 8'h1, n < 200);
   endtask
   task give_verdict;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      tick(3000);
      err_count = err_count + 1;
      give_verdict;
   end
   initial begin
      tick(2);
      rst = 1'h0;
      wait_run;
      chk("cause", `CAUSE_POR, reset_cause);
      chk("idle", `IDLE_RESET, idle_const_lat);
      chk("ret", 8'h0, ret_data);
      $display("test defaults done");
      cfg_const_lat = 1'h1;
      ret_mask_in = 8'hff;
      ret_data_in = 8'ha5;
      cfg_write = 1'h1;
      ret_write = 1'h1;
      tick(1);
      cfg_write = 1'h0;
      ret_write = 1'h0;
      tick(1);
      chk("idle", `IDLE_CONST, idle_const_lat);
      idle_req = 1'h1;
      tick(4);
      chk("state", `ST_IDLE, power_state);
      chk("cpu", 8'h0, cpu_clk_en);
      idle_req = 1'h0;
      tick(2);
      chk("cpu", 8'h0, cpu_clk_en);
      tick(1);
      chk("cpu", 8'h1, cpu_clk_en);
      wait_run;
      soft_reset_req = 1'h1;
      tick(1);
      soft_reset_req = 1'h0;
      wait_run;
      chk("cause", `CAUSE_SOFT, reset_cause);
      chk("ret", 8'ha5, ret_data);
      $display("test idle and soft done");
      wdt_expired = 1'h1;
      tick(6);
      wdt_expired = 1'h0;
      wait_run;
      chk("cause", `CAUSE_WDT, reset_cause);
      brownout = 1'h1;
      tick(6);
      brownout = 1'h0;
      wait_run;
      chk("cause", `CAUSE_BOD, reset_cause);
      fire = 4'h1;
      tick(1);
      fire = 4'h0;
      wait_run;
      chk("cause", `CAUSE_PIN, reset_cause);
      $display("test reset sources done");
      for (i = 0; i < 4; i = i + 1) begin
         off_req = 1'h1;
         tick(1);
         off_req = 1'h0;
         tick(3);
         soft_reset_req = 1'h1;
         wdt_expired = 1'h1;
         tick(1);
         soft_reset_req = 1'h0;
         wdt_expired = 1'h0;
         tick(8);
         chk("state", `ST_OFF, power_state);
         fire = 4'h1 << i;
         tick(1);
         fire = 4'h0;
         wait_run;
         chk("cause", `CAUSE_WAKE, reset_cause);
         chk("ret", 8'ha5, ret_data);
      end
      $display("test deep-off wake done");
      give_verdict;
   end
endmodule
